// >>> flyback_pkg.sv
// Purpose: shared constants and types of the flyback switch controller
// Assumes: sys_clk at 250 MHz, analog levels arrive as comparator bits
// Notes: thermal pin code is 4 mV per step
//
// What this block does
// - valley switching while in constant current mode
// - turn on at drain voltage minimum
// - skip valleys above switching frequency ceiling
// - extend off-time until aux falling edge
// - latch feedback value from aux every cycle
// - line over 1.73V for 15 halves trips
// - aux over maximum two cycles trips
// - overvoltage stops switching, stays biased
// - lockout after fault starts fresh soft-start
// - three failed starts enter inactive state
// - inactive state reactivates after 29 attempts
// - discharged supply returns to initial condition
// - long discharge pause, typically 3 to 5 s
// - overcurrent ends gate pulse until next cycle
// - keep switching, truncate each overcurrent pulse
// - shorted sense resistor shuts down after start
// - bias thermal pin and measure its voltage
// - step current down with 84 mV hysteresis
// - reduce from upper level, 1% at lower
// - thermal pin near ground forces shutdown
// - constant current, never continuous conduction
// - start above start level, stop below lockout
package flyback_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_FREQ_KHZ = 250000;
  localparam int unsigned SW_FREQ_CEIL_KHZ = 100;
  localparam int unsigned MIN_PERIOD_CYC =
    (CLK_FREQ_KHZ + SW_FREQ_CEIL_KHZ - 1) / SW_FREQ_CEIL_KHZ;
  localparam int unsigned MAX_ON_US = 10;
  localparam int unsigned MAX_ON_CYC = MAX_ON_US * CLK_FREQ_KHZ / 1000;
  localparam int unsigned SOFT_INIT_CYC = 64;
  localparam int unsigned SOFT_STEP_CYC = 16;
  // ==========================================================
  // widths and fault counts
  localparam int unsigned ON_W = 12;
  localparam int unsigned FB_W = 12;
  localparam int unsigned THERM_W = 8;
  localparam int unsigned PCT_W = 7;
  localparam int unsigned VIN_OV_RUN = 15;
  localparam int unsigned VOUT_OV_RUN = 2;
  localparam int unsigned START_TRIES = 3;
  localparam int unsigned REACTIVATE_TRIES = 29;
  // ==========================================================
  // thermal pin levels in codes
  localparam int unsigned THERM_LSB_MV = 4;
  localparam int unsigned HYST_MV = 84;
  localparam logic [7:0] HYST_CODE = 8'(HYST_MV / THERM_LSB_MV);
  localparam logic [7:0] PLIM_UPPER_CODE = 8'hc8;
  localparam logic [7:0] PLIM_LOWER_CODE = 8'h32;
  localparam logic [7:0] SHUTDOWN_CODE = 8'h19;
  localparam logic [3:0] NSTEP = 4'h9;
  localparam logic [7:0] STEPW = 8'(32'(PLIM_UPPER_CODE - PLIM_LOWER_CODE)
                                    / 32'(NSTEP));
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [6:0] PCT_MIN = 7'h01;
  localparam logic [6:0] PCT_STEP = 7'((PCT_FULL - PCT_MIN) / 7'(NSTEP));

  // switching states
  typedef enum logic [3:0] {
    SW_IDLE   = 4'h1,
    SW_ON     = 4'h2,
    SW_DEMAG  = 4'h4,
    SW_VALLEY = 4'h8
  } sw_state_t;

  // lower edge of a power limiting step
  function automatic logic [7:0] step_edge(input logic [3:0] lvl);
    step_edge = PLIM_UPPER_CODE - 8'(lvl * STEPW);
  endfunction
endpackage

// >>> flyback_switch_and_fault_control.sv
// Purpose: flyback gate timing, fault protection, thermal limiting
// Assumes: analog comparisons come in as synchronous bits
// Notes: regulation loop outside sets the requested on-time
`timescale 1ns/10ps
`default_nettype none
module flyback_switch_and_fault_control (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // supply rail status
  input wire logic supply_start_ok,
  input wire logic supply_lockout,
  input wire logic supply_discharged,
  // switching sense
  input wire logic cc_mode,
  input wire logic [flyback_pkg::ON_W-1:0] on_time_req,
  input wire logic aux_fall,
  input wire logic valley_seen,
  input wire logic aux_over_max,
  input wire logic [flyback_pkg::FB_W-1:0] feedback_sample,
  // protection sense
  input wire logic line_half_tick,
  input wire logic line_over_limit,
  input wire logic overcurrent_hit,
  input wire logic sense_short,
  // thermal pin code
  input wire logic [flyback_pkg::THERM_W-1:0] thermal_code,
  // gate and feedback
  output logic gate_drive,
  output logic [flyback_pkg::FB_W-1:0] feedback_level,
  output logic feedback_valid,
  // fault status
  output logic input_overvoltage_trip,
  output logic output_overvoltage_trip,
  output logic sense_resistor_short_guard,
  output logic controller_inactive,
  output logic controller_running,
  // thermal limit
  output logic thermal_pin_bias_en,
  output logic thermal_shutdown,
  output logic [flyback_pkg::PCT_W-1:0] current_pct
);
  import flyback_pkg::*;

  // ==========================================================
  // restart sequencer
  restart_if sif ();
  logic in_ov, out_ov, srs_q, therm_shut_q, bias_q;
  wire fault_any = in_ov | out_ov | srs_q;

  assign sif.start_req = supply_start_ok;
  assign sif.lockout = supply_lockout;
  assign sif.discharged = supply_discharged;
  assign sif.fault = fault_any;

  restart_seq u_seq (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .sif     (sif)
  );

  // switching allowed only when started, fault free and cool
  wire go = sif.run & ~fault_any & ~therm_shut_q;

  // ==========================================================
  // switching cycle state machine
  sw_state_t state_q, state_d;
  logic [ON_W-1:0] on_cnt_q, soft_q;
  logic [ON_W-1:0] period_q;
  logic gate_q, cyc_over_q, fb_valid_q;
  logic [FB_W-1:0] fb_q;

  // on-time limit: soft-start ramp, request, hard cap
  wire [ON_W-1:0] on_lim = (on_time_req < soft_q) ? on_time_req : soft_q;
  wire on_done = (on_cnt_q + 12'h001 >= on_lim);
  wire period_ok = (period_q >= ON_W'(MIN_PERIOD_CYC));
  wire valley_ok = cc_mode ? valley_seen : 1'b1;
  wire demag_end = (state_q == SW_DEMAG) & aux_fall;
  wire cyc_over = cyc_over_q | aux_over_max;

  // next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SW_IDLE: begin
        if (go) begin
          state_d = SW_ON;
        end
      end
      SW_ON: begin
        if (overcurrent_hit || on_done) begin
          state_d = SW_DEMAG;
        end
      end
      SW_DEMAG: begin
        if (aux_fall) begin
          state_d = SW_VALLEY;
        end
      end
      SW_VALLEY: begin
        if (valley_ok && period_ok) begin
          state_d = SW_ON;
        end
      end
    endcase
    if (!go) begin
      state_d = SW_IDLE;
    end
  end

  // state and gate register
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= SW_IDLE;
      gate_q <= 1'b0;
    end else begin
      state_q <= state_d;
      gate_q <= (state_d == SW_ON);
    end
  end

  // on-time and period counters
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      on_cnt_q <= '0;
      period_q <= '0;
    end else if (state_q != SW_ON && state_d == SW_ON) begin
      on_cnt_q <= '0;
      period_q <= '0;
    end else begin
      on_cnt_q <= on_cnt_q + 12'h001;
      period_q <= period_ok ? period_q : period_q + 12'h001;
    end
  end

  // soft-start ramp widens each pulse up to the cap
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !go) begin
      soft_q <= ON_W'(SOFT_INIT_CYC);
    end else if (state_q == SW_VALLEY && state_d == SW_ON) begin
      soft_q <= (soft_q >= ON_W'(MAX_ON_CYC - SOFT_STEP_CYC)) ?
                ON_W'(MAX_ON_CYC) : soft_q + ON_W'(SOFT_STEP_CYC);
    end
  end

  // feedback capture at the aux knee
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      fb_q <= '0;
      fb_valid_q <= 1'b0;
    end else if (demag_end) begin
      fb_q <= feedback_sample;
      fb_valid_q <= 1'b1;
    end
  end

  // aux over-limit seen anywhere in the off-time
  always_ff @(posedge sys_clk) begin
    if (!rst_n || state_q == SW_ON) begin
      cyc_over_q <= 1'b0;
    end else if (aux_over_max) begin
      cyc_over_q <= 1'b1;
    end
  end

  // ==========================================================
  // over-voltage run counters, cleared on lockout or discharge
  wire ov_clear = supply_lockout | supply_discharged;

  ov_counter #(.RUN(VIN_OV_RUN)) u_vin_ov (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clear   (ov_clear),
    .tick    (line_half_tick),
    .over    (line_over_limit),
    .trip    (in_ov)
  );

  ov_counter #(.RUN(VOUT_OV_RUN)) u_vout_ov (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clear   (ov_clear),
    .tick    (demag_end),
    .over    (cyc_over),
    .trip    (out_ov)
  );

  // sense resistor short, only checked once started
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      srs_q <= 1'b0;
    end else begin
      srs_q <= (srs_q & ~ov_clear) | (sense_short & sif.run);
    end
  end

  // ==========================================================
  // thermal pin limiter
  logic [3:0] lvl_q;
  logic [PCT_W-1:0] pct_q;
  wire [7:0] edge_here = step_edge(lvl_q);
  wire [7:0] edge_back = step_edge(lvl_q - 4'h1) + HYST_CODE;
  wire step_down = (lvl_q < NSTEP) && (thermal_code < edge_here);
  wire step_up = (lvl_q != 4'h0) && (thermal_code >= edge_back);

  // level steps with hysteresis on the way back
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      lvl_q <= 4'h0;
    end else if (step_down) begin
      lvl_q <= lvl_q + 4'h1;
    end else if (step_up) begin
      lvl_q <= lvl_q - 4'h1;
    end
  end

  // percentage, shutdown and pin bias
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pct_q <= PCT_FULL;
      therm_shut_q <= 1'b0;
      bias_q <= 1'b0;
    end else begin
      pct_q <= PCT_FULL - 7'(lvl_q * PCT_STEP);
      therm_shut_q <= (thermal_code < SHUTDOWN_CODE);
      bias_q <= 1'b1;
    end
  end

  // ==========================================================
  // outputs, all from flops
  assign gate_drive = gate_q;
  assign feedback_level = fb_q;
  assign feedback_valid = fb_valid_q;
  assign input_overvoltage_trip = in_ov;
  assign output_overvoltage_trip = out_ov;
  assign sense_resistor_short_guard = srs_q;
  assign controller_inactive = sif.inactive;
  assign controller_running = sif.run;
  assign thermal_pin_bias_en = bias_q;
  assign thermal_shutdown = therm_shut_q;
  assign current_pct = pct_q;

  // ==========================================================
  // checks
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  oc_cut_a: assert property (gate_q && overcurrent_hit |=> !gate_q)
    else $error("gate kept on past overcurrent");
  fault_stop_a: assert property (fault_any |=> !gate_q)
    else $error("switching during fault");
  demag_wait_a: assert property ($rose(gate_q) && $past(state_q) != SW_IDLE
      |-> $past(state_q) == SW_VALLEY)
    else $error("turn-on before demagnetising ended");
  valley_a: assert property ($rose(gate_q) && $past(state_q) == SW_VALLEY
      && $past(cc_mode) |-> $past(valley_seen))
    else $error("turn-on off valley");
  freq_cap_a: assert property ($rose(gate_q) && $past(state_q) == SW_VALLEY
      |-> $past(period_q) >= ON_W'(MIN_PERIOD_CYC))
    else $error("switching frequency above ceiling");
  fb_latch_a: assert property (demag_end
      |=> fb_q == $past(feedback_sample))
    else $error("feedback not captured");
  therm_off_a: assert property (thermal_code < SHUTDOWN_CODE
      |=> therm_shut_q ##1 !gate_q)
    else $error("thermal shutdown missed");
  pct_floor_a: assert property (lvl_q == NSTEP |=> pct_q == PCT_MIN)
    else $error("lowest step not 1 percent");

  // ==========================================================
  // switching cycle checks

  // pulse never outlasts the hard on-time cap
  on_cap_a: assert property (gate_q |-> on_cnt_q < ON_W'(MAX_ON_CYC))
    else $error("on-time above cap");

  // soft-start ramp stays inside the cap
  soft_cap_a: assert property (soft_q <= ON_W'(MAX_ON_CYC))
    else $error("soft-start above cap");

  // no go means the gate is off a cycle later
  no_go_a: assert property (!go |=> !gate_q)
    else $error("gate on without go");

  // idle with go turns the gate on next
  idle_start_a: assert property (state_q == SW_IDLE && go |=> gate_q)
    else $error("start pulse missing");

  // gate held on until a cut reason appears
  on_hold_a: assert property (state_q == SW_ON && go && !on_done
      && !overcurrent_hit |=> gate_q)
    else $error("pulse ended early");

  // off-time extended while the knee is missing
  knee_wait_a: assert property (state_q == SW_DEMAG && !aux_fall
      |=> !gate_q)
    else $error("turn-on without aux knee");

  // period floor holds the valley wait
  skip_fast_a: assert property (state_q == SW_VALLEY && !period_ok
      |=> !gate_q)
    else $error("valley taken above ceiling");

  // constant current waits for a valley
  cc_valley_a: assert property (state_q == SW_VALLEY && cc_mode
      && !valley_seen |=> !gate_q)
    else $error("cc turn-on off valley");

  // without cc mode the floor alone gates turn-on
  free_turn_a: assert property (state_q == SW_VALLEY && !cc_mode
      && period_ok && go |=> gate_q)
    else $error("turn-on delayed outside cc");

  // overcurrent leaves the on state at once
  oc_leave_a: assert property (state_q == SW_ON && overcurrent_hit
      |=> state_q inside {SW_DEMAG, SW_IDLE})
    else $error("on state kept past overcurrent");

  // each knee marks the feedback value valid
  fb_valid_a: assert property (demag_end |=> fb_valid_q)
    else $error("feedback not marked valid");

  // ==========================================================
  // protection and thermal checks

  // stopped sequencer stops the gate
  run_gate_a: assert property (!sif.run |=> !gate_q)
    else $error("gate on while not running");

  // lockout drops the run grant
  lockout_stop_a: assert property (supply_lockout |=> !sif.run)
    else $error("running below lockout");

  // short seen while running is latched
  short_latch_a: assert property (sense_short && sif.run |=> srs_q)
    else $error("sense short not latched");

  // a latched short keeps the gate off
  short_off_a: assert property (srs_q |=> !gate_q)
    else $error("switching with sense short");

  // bias current on once out of reset
  bias_on_a: assert property (1'b1 |=> bias_q)
    else $error("thermal pin bias off");

  // limiter level never passes the last step
  lvl_max_a: assert property (lvl_q <= NSTEP)
    else $error("limiter level out of range");

  // current percent within full and minimum
  pct_span_a: assert property (pct_q >= PCT_MIN && pct_q <= PCT_FULL)
    else $error("current percent out of range");
endmodule
`default_nettype wire

// >>> flyback_switch_and_fault_control_tb.sv
// Purpose: self-checking bench of the flyback switch controller
// Assumes: 250 MHz sys_clk, power stage model on the far side
// Notes: feedback captures are queued and compared one cycle later
`timescale 1ns/10ps
`default_nettype none
module flyback_switch_and_fault_control_tb;
  import flyback_pkg::*;
  logic sys_clk = 0, rst_n = 0, supply_start_ok = 0, supply_lockout = 0;
  logic supply_discharged = 0, cc_mode = 1, line_half_tick = 0;
  logic line_over_limit = 0, sense_short = 0, aux_over_max = 0;
  logic hold_aux = 0, oc_en = 0, aux_fall, valley_seen, overcurrent_hit;
  logic [11:0] on_time_req = 12'h200, feedback_sample = 12'h000;
  logic [7:0] thermal_code = 8'hff;
  logic gate_drive, feedback_valid, input_overvoltage_trip, gate_q = 0;
  logic output_overvoltage_trip, sense_resistor_short_guard;
  logic controller_inactive, controller_running, thermal_pin_bias_en;
  logic thermal_shutdown;
  logic [11:0] feedback_level;
  logic [6:0] current_pct;
  logic [11:0] fb_q[$];
  int error_cnt = 0, checks_done = 0, cyc = 0, last_rise = 0, v_cyc = 0;
  int rises = 0, r0 = 0, tl = 0, seed = 86587;
  logic [7:0] tcodes [4] = '{8'hc7, 8'hb0, 8'h80, 8'h30};

  always #2 sys_clk = ~sys_clk;

  flyback_switch_and_fault_control u_flyback_switch_and_fault_control (
    .sys_clk, .rst_n, .supply_start_ok, .supply_lockout,
    .supply_discharged, .cc_mode, .on_time_req, .aux_fall, .valley_seen,
    .aux_over_max, .feedback_sample, .line_half_tick, .line_over_limit,
    .overcurrent_hit, .sense_short, .thermal_code, .gate_drive,
    .feedback_level, .feedback_valid, .input_overvoltage_trip,
    .output_overvoltage_trip, .sense_resistor_short_guard,
    .controller_inactive, .controller_running, .thermal_pin_bias_en,
    .thermal_shutdown, .current_pct);

  power_stage_model u_power_stage_model (.sys_clk, .gate_drive,
    .hold_aux, .oc_en, .aux_fall, .valley_seen, .overcurrent_hit);

  // =========================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("errors=%0d checks=%0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // one-cycle strobe; bits are tick, lockout, discharged, start
  task automatic pulse(input logic [3:0] sel);
    {line_half_tick, supply_lockout, supply_discharged, supply_start_ok} <=
      sel;
    tk(1);
    {line_half_tick, supply_lockout, supply_discharged, supply_start_ok} <=
      4'h0;
  endtask

  task automatic wait_rises(input int n, input int lim);
    int goal;
    goal = rises + n;
    while (rises < goal && lim > 0) begin
      tk(1);
      lim--;
    end
    check(rises >= goal, 1);
  endtask

  task automatic ticks(input int n, input logic over);
    tk(1);
    line_over_limit <= over;
    repeat (n) begin
      pulse(4'h8);
      tk(3);
    end
  endtask

  // expected percent on a falling thermal code
  function automatic logic [6:0] pct_of(input int c);
    while (tl < 9 && c < 200 - 16 * tl) tl++;
    return 7'(100 - 11 * tl);
  endfunction

  // =========================================================
  // output monitor: feedback notes, gate timing, timeout
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 90000) begin
      error_cnt++;
      complete_run();
    end
    feedback_sample <= 12'($random(seed));
    if (fb_q.size() > 0) check(feedback_level, fb_q.pop_front());
    if (aux_fall && !gate_drive && controller_running)
      fb_q.push_back(feedback_sample);
    if (valley_seen) v_cyc = cyc;
    if (gate_drive && !gate_q) begin
      rises++;
      if (last_rise > 0) begin
        check(cyc - last_rise >= MIN_PERIOD_CYC, 1);
        if (cc_mode) check(cyc - v_cyc inside {[1:2]}, 1);
      end
      last_rise = cyc;
    end
    if (!gate_drive && gate_q && oc_en) check(cyc - last_rise <= 13, 1);
    if (!controller_running) last_rise = 0;
    gate_q = gate_drive;
  end

  // =========================================================
  // main sequence
  initial begin
    tk(8);
    rst_n <= 1'b1;
    #1 check({gate_drive, controller_running, controller_inactive,
      feedback_valid, thermal_pin_bias_en}, 0);
    check(current_pct, 7'h64);
    tk(2);
    #1 check(thermal_pin_bias_en, 1);
    // thermal steps down, hysteresis, shutdown
    foreach (tcodes[i]) begin
      tk(1);
      thermal_code <= tcodes[i];
      tk(30);
      #1 check(current_pct, pct_of(tcodes[i]));
    end
    tk(1);
    thermal_code <= 8'h5c;
    tk(30);
    #1 check(current_pct, 7'h01);
    tk(1);
    thermal_code <= 8'h5d;
    tk(30);
    #1 check(current_pct, 7'h0c);
    tk(1);
    thermal_code <= 8'h19;
    tk(3);
    #1 check(thermal_shutdown, 0);
    tk(1);
    thermal_code <= 8'h18;
    tk(3);
    #1 check(thermal_shutdown, 1);
    tk(1);
    thermal_code <= 8'hff;
    tk(80);
    #1 check({thermal_shutdown, current_pct}, 8'h64);
    // line over-voltage run, broken once
    ticks(14, 1);
    ticks(1, 0);
    ticks(14, 1);
    #1 check(input_overvoltage_trip, 0);
    ticks(1, 1);
    #1 check(input_overvoltage_trip, 1);
    tk(1);
    line_over_limit <= 1'b0;
    pulse(4'h4);
    pulse(4'h2);
    tk(1);
    #1 check(input_overvoltage_trip, 0);
    // valley switching, then fixed floor without cc mode
    tk(1);
    pulse(4'h1);
    wait_rises(6, 20000);
    check(feedback_valid, 1);
    cc_mode <= 1'b0;
    wait_rises(3, 10000);
    cc_mode <= 1'b1;
    wait_rises(1, 4000);
    hold_aux <= 1'b1;
    r0 = rises;
    tk(6000);
    check(rises == r0, 1);
    hold_aux <= 1'b0;
    wait_rises(1, 4000);
    oc_en <= 1'b1;
    wait_rises(3, 10000);
    oc_en <= 1'b0;
    // aux over-voltage in two off-times
    aux_over_max <= 1'b1;
    for (int i = 0; i < 8000 && !output_overvoltage_trip; i++) tk(1);
    tk(2);
    #1 check({output_overvoltage_trip, gate_drive}, 2'b10);
    r0 = rises;
    tk(3000);
    check({rises == r0, controller_running}, 2'b10);
    aux_over_max <= 1'b0;
    pulse(4'h4);
    pulse(4'h2);
    tk(1);
    #1 check(output_overvoltage_trip, 0);
    // three failed starts, inactive, 29th start wakes
    repeat (3) begin
      tk(1);
      pulse(4'h1);
      tk(1);
      #1 check(controller_running, 1);
      tk(1);
      sense_short <= 1'b1;
      tk(3);
      #1 check({sense_resistor_short_guard, controller_running}, 2'b10);
      tk(1);
      sense_short <= 1'b0;
      pulse(4'h4);
      tk(1);
      #1 check(sense_resistor_short_guard, 0);
    end
    check(controller_inactive, 1);
    repeat (28) begin
      tk(1);
      pulse(4'h1);
      tk(2);
      #1 check(controller_running, 0);
    end
    tk(1);
    pulse(4'h1);
    tk(1);
    #1 check({controller_running, controller_inactive}, 2'b10);
    tk(1);
    pulse(4'h2);
    tk(1);
    #1 check({controller_running, controller_inactive}, 2'b00);
    complete_run();
  end
endmodule
`default_nettype wire

// >>> ov_counter.sv
// Purpose: consecutive over-limit run counter with sticky trip
// Assumes: one tick per observed cycle
// Notes: a tick without over clears the run
`timescale 1ns/10ps
`default_nettype none
module ov_counter #(
  parameter int unsigned RUN = 15
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // observations
  input wire logic clear,
  input wire logic tick,
  input wire logic over,
  // result
  output logic trip
);
  logic [4:0] cnt_q;
  logic trip_q;
  wire hit = tick & over & (cnt_q == 5'(RUN - 1));

  // count unbroken runs, set beats clear
  always_ff @(posedge sys_clk) begin
    if (!rst_n || clear) begin
      cnt_q <= 5'h00;
    end else if (tick) begin
      cnt_q <= over ? cnt_q + 5'h01 : 5'h00;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trip_q <= 1'b0;
    end else begin
      trip_q <= (trip_q & ~clear) | hit;
    end
  end
  assign trip = trip_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  run_trip_a: assert property ($rose(trip_q) |-> $past(hit))
    else $error("trip without full run");
  break_run_a: assert property (tick && !over && !clear |=> cnt_q == 0)
    else $error("run not cleared");
endmodule
`default_nettype wire

// >>> power_stage_model.sv
// Purpose: flyback power stage stand-in facing the switch controller
// Assumes: one sys_clk domain, gate active high
// Notes: knee 40 cycles after turn-off, then a valley every 200 cycles
`timescale 1ns/10ps
`default_nettype none
module power_stage_model (
  // clock and gate
  input wire logic sys_clk,
  input wire logic gate_drive,
  // scenario controls
  input wire logic hold_aux,
  input wire logic oc_en,
  // sense outputs
  output logic aux_fall,
  output logic valley_seen,
  output logic overcurrent_hit
);
  int on_cnt = 0;
  int off_cnt = 0;
  logic knee_q = 1'b0;

  initial begin
    aux_fall = 1'b0;
    valley_seen = 1'b0;
    overcurrent_hit = 1'b0;
  end

  // current ramp, one knee per off-time, ringing valleys after it
  always @(posedge sys_clk) begin
    on_cnt <= gate_drive ? on_cnt + 1 : 0;
    off_cnt <= gate_drive ? 0 : off_cnt + 1;
    overcurrent_hit <= oc_en && gate_drive && on_cnt >= 9;
    aux_fall <= !gate_drive && !knee_q && !hold_aux && off_cnt >= 40;
    knee_q <= !gate_drive && (knee_q || (!hold_aux && off_cnt >= 40));
    valley_seen <= !gate_drive && knee_q && (off_cnt % 200 == 0);
  end
endmodule
`default_nettype wire

// >>> restart_if.sv
// Purpose: restart sequencer hand-shake signals
// Assumes: all signals on sys_clk
// Notes: seq side owns run and inactive
`timescale 1ns/10ps
`default_nettype none
interface restart_if;
  logic start_req;
  logic lockout;
  logic discharged;
  logic fault;
  logic run;
  logic inactive;
  modport seq (input start_req, lockout, discharged, fault,
               output run, inactive);
  modport ctl (output start_req, lockout, discharged, fault,
               input run, inactive);
endinterface
`default_nettype wire

// >>> restart_seq.sv
// Purpose: start attempt and inactive state sequencer
// Assumes: start_req is one pulse per supply start
// Notes: attempt count kept until supply discharged or a wake start
`timescale 1ns/10ps
`default_nettype none
module restart_seq (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // hand-shake
  restart_if.seq sif
);
  import flyback_pkg::*;
  logic run_q, inactive_q;
  logic [1:0] tries_q;
  logic [4:0] skip_q;
  wire wake = sif.start_req & ~run_q & inactive_q &
              (skip_q == 5'(REACTIVATE_TRIES - 1));

  // attempt bookkeeping
  always_ff @(posedge sys_clk) begin
    if (!rst_n || sif.discharged) begin
      run_q <= 1'b0;
      inactive_q <= 1'b0;
      tries_q <= 2'h0;
      skip_q <= 5'h00;
    end else if (sif.fault && run_q) begin
      run_q <= 1'b0;
      tries_q <= tries_q + 2'h1;
      inactive_q <= (tries_q == 2'(START_TRIES - 1));
    end else if (sif.lockout) begin
      run_q <= 1'b0;
    end else if (sif.start_req && !run_q) begin
      if (!inactive_q || wake) begin
        run_q <= 1'b1;
        inactive_q <= 1'b0;
        tries_q <= wake ? 2'h0 : tries_q;
        skip_q <= 5'h00;
      end else begin
        skip_q <= skip_q + 5'h01;
      end
    end
  end
  assign sif.run = run_q;
  assign sif.inactive = inactive_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  three_tries_a: assert property ($rose(inactive_q) |->
      $past(tries_q) == 2'(START_TRIES - 1))
    else $error("inactive before third failure");
  wake_count_a: assert property ($fell(inactive_q) && !$past(sif.discharged)
      |-> $past(skip_q) == 5'(REACTIVATE_TRIES - 1))
    else $error("woke before 29 attempts");
  deaf_a: assert property (inactive_q && !wake |=> !run_q)
    else $error("started while inactive");
endmodule
`default_nettype wire
